// File: dds_serial_write_port.sv
// Serial write port, register bank and phase accumulator of the synthesizer
`timescale 1ns/10ps
`default_nettype none
`include "dds_consts.svh"
module dds_serial_write_port (
   input wire logic i_clk, // Master clock, 25 MHz
   input wire logic i_arst_n, // Asynchronous reset, active low
   input wire dds_pkg::serial_pins_t i_pins, // Frame sync, shift clock, serial data
   input wire logic i_freq_reg_select_pin, // Chooses frequency word 0 or 1
   input wire logic [1:0] i_phase_sel, // Chooses one of four phase offsets
   output logic [`OUT_BITS-1:0] o_phase, // Phase word to the cosine table
   output logic o_word_valid, // Pulse: a whole word was taken
   output var dds_pkg::serial_word_t o_last_word // Last word taken
);
   import dds_pkg::*;

   // ************************************************************
   // Input sampling
   // ************************************************************
   // shift clock rate limit
   // Shift clock is oversampled; at 25 MHz master clock this limits the
   // usable shift rate, the trade for a single clock domain design.
   // High and low phases of the shift clock must each last longer than one
   // master clock, so the full 20 MHz host rate needs a faster master clock.
   logic [2:0] sclk_reg, sclk_next;
   logic [1:0] fs_reg, fs_next;
   logic [1:0] sd_reg, sd_next;
   logic fall;
   // Shift the three pins into their sampling chains
   always_comb begin
      sclk_next = {sclk_reg[1:0], i_pins.sclk};
      fs_next = {fs_reg[0], i_pins.frame_sync_n};
      sd_next = {sd_reg[0], i_pins.serial_data_in};
   end
   // Sampling chains; idle high levels preloaded so reset makes no false edge
   // Shift clock chain is one stage deeper than the data chain; stage 1 of each is read, so each bit is seen aligned
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sclk_reg <= 3'h7;
         fs_reg <= 2'h3;
         sd_reg <= 2'h0;
      end else begin
         sclk_reg <= sclk_next;
         fs_reg <= fs_next;
         sd_reg <= sd_next;
      end
   end
   // falling edge detect
   // Stages 1 and 2 only, so the first sampling stage is never read here
   // any idle level
   // Edge based, so a shift clock resting high or resting low looks the same
   assign fall = sclk_reg[2] & ~sclk_reg[1];

   // ************************************************************
   // Word receiver
   // ************************************************************
   rx_state_t state_reg, state_next;
   logic [`WORD_BITS-1:0] shift_reg, shift_next;
   logic [4:0] cnt_reg, cnt_next;
   logic valid_reg, valid_next;
   serial_word_t last_reg, last_next;
   // Counts falls inside one low sync; the word is only handed on when the
   // count reaches sixteen, so a short frame never touches the register bank.
   // Next state of the receiver
   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      valid_next = 1'b0;
      last_next = last_reg;
      case (state_reg)
         ST_IDLE: begin
            // Falls seen before the sync goes low are not counted
            cnt_next = 5'h00;
            if (!fs_reg[1]) begin
               state_next = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (fs_reg[1]) begin
               state_next = ST_IDLE;
            end else if (fall) begin
               shift_next = {shift_reg[`WORD_BITS-2:0], sd_reg[1]};
               cnt_next = cnt_reg + 5'h01;
               if (cnt_reg == 5'(`WORD_BITS - 1)) begin
                  state_next = ST_DONE;
                  valid_next = 1'b1;
                  last_next = serial_word_t'({shift_reg[`WORD_BITS-2:0], sd_reg[1]});
               end
            end
         end
         ST_DONE: begin
            // Extra edges in the same frame are ignored until sync rises
            if (fs_reg[1]) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end
   // Receiver registers
   // Reset parks the receiver in idle with an empty word
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= ST_IDLE;
         shift_reg <= 16'h0000;
         cnt_reg <= 5'h00;
         valid_reg <= 1'b0;
         last_reg <= '0;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         valid_reg <= valid_next;
         last_reg <= last_next;
      end
   end

   // ************************************************************
   // Register bank
   // ************************************************************
   // Address map of the word's address field:
   // bit3=0 selects a frequency word, bit2 the word, bits1:0 the byte lane
   // bit3=1 selects a phase offset, bits2:1 the offset, bit0 high or low byte
   // The control field is not decoded, so every complete word writes a byte;
   // a write takes effect on the clock after the valid pulse.
   logic [`ACC_BITS-1:0] freq_reg [2];
   logic [`ACC_BITS-1:0] freq_next [2];
   logic [15:0] phase_reg [4];
   logic [15:0] phase_next [4];
   genvar gi;
   // One pass per phase offset; the first two passes also hold the frequency words
   generate
      for (gi = 0; gi < 4; gi++) begin : g_regs
         always_comb begin
            phase_next[gi] = phase_reg[gi];
            if (valid_reg && last_reg.addr[3] && last_reg.addr[2:1] == 2'(gi)) begin
               if (last_reg.addr[0]) begin
                  phase_next[gi][15:8] = last_reg.data;
               end else begin
                  phase_next[gi][7:0] = last_reg.data;
               end
            end
         end
         // Phase offset storage; only the low 12 bits reach the adder
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               phase_reg[gi] <= 16'h0000;
            end else begin
               phase_reg[gi] <= phase_next[gi];
            end
         end
         if (gi < 2) begin : g_freq
            always_comb begin
               freq_next[gi] = freq_reg[gi];
               if (valid_reg && !last_reg.addr[3] && last_reg.addr[2] == 1'(gi)) begin
                  freq_next[gi][8*last_reg.addr[1:0] +: 8] = last_reg.data;
               end
            end
            // Frequency word storage, one byte lane per write
            always_ff @(posedge i_clk or negedge i_arst_n) begin
               if (!i_arst_n) begin
                  freq_reg[gi] <= 32'h00000000;
               end else begin
                  freq_reg[gi] <= freq_next[gi];
               end
            end
         end
      end
   endgenerate

   // ************************************************************
   // Phase accumulator
   // ************************************************************
   logic [`ACC_BITS-1:0] acc_reg, acc_next;
   logic [`OUT_BITS-1:0] ph_reg, ph_next;
   // Next accumulator and phase word
   always_comb begin
      // accumulate selected word
      // Wraps modulo 2^32, which is the intended turn of the phase wheel
      acc_next = acc_reg + freq_reg[i_freq_reg_select_pin];
      ph_next = acc_reg[`ACC_BITS-1 -: `OUT_BITS] + phase_reg[i_phase_sel][`PHASE_BITS-1:0];
   end
   // Accumulator and phase registers
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         acc_reg <= 32'h00000000;
         ph_reg <= 12'h000;
      end else begin
         acc_reg <= acc_next;
         ph_reg <= ph_next;
      end
   end
   // Outputs come straight from their registers
   assign o_phase = ph_reg;
   assign o_word_valid = valid_reg;
   assign o_last_word = last_reg;
endmodule // dds_serial_write_port
`default_nettype wire

// File: dds_consts.svh
// Constants for the serial write port of the synthesizer core
`ifndef DDS_CONSTS_SVH
`define DDS_CONSTS_SVH
`define WORD_BITS 16
`define CTRL_MSB 15
`define CTRL_LSB 12
`define ADDR_MSB 11
`define ADDR_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define ACC_BITS 32
`define PHASE_BITS 12
`define OUT_BITS 12
`define CTRL_WR_LO 4'h0
`define CTRL_WR_HI 4'h1
`define SCLK_MAX_MHZ 20
`define MCLK_MAX_MHZ 50
`endif

// File: dds_pkg.sv
// Types shared by the serial write port design
package dds_pkg;
   typedef struct packed {
      logic [3:0] ctrl;
      logic [3:0] addr;
      logic [7:0] data;
   } serial_word_t;
   typedef struct packed {
      logic frame_sync_n;
      logic sclk;
      logic serial_data_in;
   } serial_pins_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } rx_state_t;
endpackage

// File: dds_port_props.sv
// Checker on the serial pins and word outputs
`timescale 1ns/10ps
`default_nettype none
module dds_port_props (
   input wire logic i_clk, // Clock
   input wire logic i_arst_n, // Reset
   input wire dds_pkg::serial_pins_t i_pins, // Pins
   input wire logic o_word_valid, // Pulse
   input wire dds_pkg::serial_word_t o_last_word // Word
);
   import dds_pkg::*;
   logic s_reg;
   logic [15:0] sh_reg;
   logic [4:0] n_reg;
   // Shadow shifter; stops at 16 so late falls are ignored
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_reg <= 1'b0;
         sh_reg <= 16'h0000;
         n_reg <= 5'h00;
      end else begin
         s_reg <= i_pins.sclk;
         if (i_pins.frame_sync_n) n_reg <= 5'h00;
         else if (s_reg && !i_pins.sclk && n_reg < 5'h10) begin
            sh_reg <= {sh_reg[14:0], i_pins.serial_data_in};
            n_reg <= n_reg + 5'h01;
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_valid_one_pulse: assert property (
      o_word_valid |=> !o_word_valid) else $error("valid too long");
   a_valid_on_time: assert property (
      n_reg == 5'h10 && $past(n_reg) == 5'h0F |-> ##2 o_word_valid) else $error("valid late");
   a_valid_cause: assert property (
      o_word_valid |-> $past(n_reg, 2) == 5'h10) else $error("valid without word");
   a_word_fields: assert property (
      o_word_valid |-> o_last_word == sh_reg) else $error("word bits wrong");
   a_word_held: assert property (
      $changed(o_last_word) |-> o_word_valid) else $error("word changed alone");
   a_fall_sample: assert property (
      o_word_valid |-> $past(i_pins.sclk, 4) && !$past(i_pins.sclk, 3)) else $error("not on fall");
   a_sync_framed: assert property (
      o_word_valid |-> !$past(i_pins.frame_sync_n, 4)) else $error("word outside frame");
   a_reset_clean: assert property (
      $rose(i_arst_n) |-> o_last_word == 16'h0000 && !o_word_valid) else $error("reset dirty");
   c_word: cover property (o_word_valid);
   c_short: cover property ($rose(i_pins.frame_sync_n) && n_reg == 5'h08);
   c_two: cover property (o_word_valid ##[1:400] o_word_valid);
endmodule // dds_port_props
bind dds_serial_write_port dds_port_props i_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
   .i_pins(i_pins), .o_word_valid(o_word_valid), .o_last_word(o_last_word));
`default_nettype wire

// File: dds_host_model.sv
// Host that frames and shifts words into the port
`timescale 1ns/10ps
`default_nettype none
module dds_host_model (
   input wire logic i_clk, // Clock
   output var dds_pkg::serial_pins_t o_pins // Pins to the port
);
   import dds_pkg::*;
   initial o_pins = 3'b110;
   task automatic send(input logic [15:0] w, input int nb, input logic idl, input logic gap);
      for (int i = 0; i < nb; i++) begin
         @(posedge i_clk);
         o_pins <= '{1'b0, 1'b1, w[15-i]};
         repeat (2) @(posedge i_clk);
         o_pins.sclk <= 1'b0;
         repeat (2) @(posedge i_clk);
         if (gap && i == 7) begin
            o_pins.sclk <= 1'b1;
            repeat (6) @(posedge i_clk);
         end
      end
      // Released data line shows the inverse, never a stale level
      o_pins <= '{1'b1, idl, ~o_pins.serial_data_in};
      repeat (6) @(posedge i_clk);
   endtask
endmodule // dds_host_model
`default_nettype wire

// File: dds_serial_write_port_bench.sv
// Self-checking bench for the serial write port
`timescale 1ns/10ps
`default_nettype none
`include "dds_consts.svh"
module dds_serial_write_port_bench;
   import dds_pkg::*;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic sel_f = 1'b0;
   logic [1:0] sel_p = 2'h0;
   serial_pins_t pins;
   logic [`OUT_BITS-1:0] ph;
   logic vld;
   serial_word_t last;
   int bad_count = 0;
   int n_compared = 0;
   int n_vld = 0;
   int cyc = 0;
   dds_host_model i_host (.i_clk(i_clk), .o_pins(pins));
   dds_serial_write_port i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_pins(pins),
      .i_freq_reg_select_pin(sel_f), .i_phase_sel(sel_p), .o_phase(ph),
      .o_word_valid(vld), .o_last_word(last));
   initial forever #20 i_clk = ~i_clk;
   // Word counter and hang limit
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (vld === 1'b1) n_vld <= n_vld + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d errors %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Each resting style of the shift clock, split bytes too
   task automatic t_styles();
      int n;
      for (int k = 0; k < 4; k++) begin
         n = n_vld;
         i_host.send(16'h0A50 + 16'(k), 16, k[0], k[1]);
         check(16'(n_vld - n), 16'h0001);
         check(last, 16'h0A50 + 16'(k));
      end
      $display("styles done");
   endtask
   // Lane 2 of word 0 makes the phase step once a cycle
   task automatic t_freq();
      logic [11:0] a;
      i_host.send(16'h0210, 16, 1'b1, 1'b0);
      @(negedge i_clk) a = ph;
      @(negedge i_clk) a = ph - a;
      check({4'h0, a}, 16'h0001);
      @(posedge i_clk) sel_f <= 1'b1;
      repeat (3) @(negedge i_clk);
      a = ph;
      @(negedge i_clk) a = ph - a;
      check({4'h0, a}, 16'h0000);
      $display("freq done");
   endtask
   // Frozen phase; offset 2 low byte shifts it by 5
   task automatic t_phase();
      logic [11:0] a;
      i_host.send(16'h0C05, 16, 1'b0, 1'b0);
      @(negedge i_clk) a = ph;
      @(posedge i_clk) sel_p <= 2'h2;
      repeat (3) @(negedge i_clk);
      a = ph - a;
      check({4'h0, a}, 16'h0005);
      $display("phase done");
   endtask
   // A frame cut after 8 bits is dropped
   task automatic t_short();
      int n;
      n = n_vld;
      i_host.send(16'h0FFF, 8, 1'b1, 1'b0);
      check(16'(n_vld - n), 16'h0000);
      check(last, 16'h0C05);
      $display("short done");
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge i_clk);
      i_arst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      t_styles();
      t_freq();
      t_phase();
      t_short();
      end_of_test();
   end
endmodule // dds_serial_write_port_bench
`default_nettype wire
